// ### common/smca_pkg.sv
package smca_pkg;

    // Operation select presented with each issued operation
    typedef enum logic [4:0] {
        OP_SADD,
        OP_UADD,
        OP_SSUB,
        OP_USUB,
        OP_SMUL,
        OP_UMUL,
        OP_SABS,
        OP_DUAL_ADD,
        OP_DUAL_SUB,
        OP_DUAL_MUL,
        OP_DUAL_ABS,
        OP_QUAD_ADD_US,
        OP_SIGNED_HALFWORD_DOT,
        OP_UNSIGNED_HALFWORD_DOT,
        OP_SIGNED_BYTE_DOT,
        OP_MIXED_BYTE_DOT,
        OP_UNSIGNED_BYTE_DOT,
        OP_MERGE_LOW,
        OP_MERGE_HIGH,
        OP_JOIN_LOW_HALFWORDS,
        OP_JOIN_HIGH_HALFWORDS,
        OP_PACK_LOW_BYTES,
        OP_QUAD_AVG,
        OP_QUAD_MUL_HIGH,
        OP_SIGNED_BYTE_SAD,
        OP_UNSIGNED_BYTE_SAD
    } smca_op_t;

    // Word ops are evaluated 66 bits wide so an unsigned 64-bit product keeps its sign room
    localparam logic signed [65:0] WIDE_S32_MAX = 66'sh0_7FFF_FFFF;
    localparam logic signed [65:0] WIDE_S32_MIN = -66'sh0_8000_0000;
    localparam logic signed [65:0] WIDE_U32_MAX = 66'sh0_FFFF_FFFF;
    localparam logic signed [65:0] WIDE_ZERO = 66'sh0_0000_0000;
    localparam logic signed [33:0] HALF_S16_MAX = 34'sh0_0000_7FFF;
    localparam logic signed [33:0] HALF_S16_MIN = -34'sh0_0000_8000;
    localparam logic signed [9:0] BYTE_U8_MAX = 10'sh0FF;
    localparam logic signed [9:0] BYTE_ZERO = 10'sh000;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [8:0] AVG_ROUND = 9'h001;
    localparam logic [31:0] ONES_PER_BYTE = 32'h0101_0101;

endpackage : smca_pkg

// ### hw/smca_alu.sv
`timescale 1ns/1ps
module smca_alu (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic opValid,
    input wire smca_pkg::smca_op_t opCode,
    input wire logic [31:0] srcA,
    input wire logic [31:0] srcB,
    output logic resValid,
    output logic [31:0] resData,
    output logic resIllegal
);
    import smca_pkg::*;

    function automatic logic [31:0] clampS32(input logic signed [65:0] v);
        if (v > WIDE_S32_MAX)
            return WIDE_S32_MAX[31:0];
        else if (v < WIDE_S32_MIN)
            return WIDE_S32_MIN[31:0];
        return v[31:0];
    endfunction : clampS32

    function automatic logic [31:0] clampU32(input logic signed [65:0] v);
        if (v > WIDE_U32_MAX)
            return WIDE_U32_MAX[31:0];
        else if (v < WIDE_ZERO)
            return WIDE_ZERO[31:0];
        return v[31:0];
    endfunction : clampU32

    function automatic logic [15:0] clampS16(input logic signed [33:0] v);
        if (v > HALF_S16_MAX)
            return HALF_S16_MAX[15:0];
        else if (v < HALF_S16_MIN)
            return HALF_S16_MIN[15:0];
        return v[15:0];
    endfunction : clampS16

    function automatic logic [9:0] absByteDiff(input logic signed [9:0] d);
        return (d < BYTE_ZERO) ? 10'(-d) : 10'(d);
    endfunction : absByteDiff

    logic signed [65:0] wideA;
    logic signed [65:0] wideB;
    logic signed [65:0] zeroA;
    logic signed [65:0] zeroB;
    logic [31:0] dualAdd;
    logic [31:0] dualSub;
    logic [31:0] dualMul;
    logic [31:0] dualAbs;
    logic [31:0] quadAdd;
    logic [31:0] quadAvg;
    logic [31:0] quadMulHigh;
    logic signed [31:0] sDot16;
    logic [31:0] uDot16;
    logic signed [31:0] sDot8;
    logic signed [31:0] mDot8;
    logic [31:0] uDot8;
    logic [31:0] sSad;
    logic [31:0] uSad;
    logic [7:0] aByte;
    logic [7:0] bByte;
    logic [15:0] aHalf;
    logic [15:0] bHalf;
    logic signed [33:0] hx;
    logic signed [33:0] hy;
    logic signed [9:0] byteSum;
    logic [8:0] avgSum;
    logic [15:0] byteProd;
    logic [31:0] next_resData;
    logic next_resValid;
    logic next_resIllegal;

    // Lane arithmetic; every lane is computed each cycle and the opcode only selects
    always_comb
    begin
        wideA = 66'($signed(srcA));
        wideB = 66'($signed(srcB));
        zeroA = $signed({34'h0_0000_0000, srcA});
        zeroB = $signed({34'h0_0000_0000, srcB});
        dualAdd = '0;
        dualSub = '0;
        dualMul = '0;
        dualAbs = '0;
        quadAdd = '0;
        quadAvg = '0;
        quadMulHigh = '0;
        sDot16 = '0;
        uDot16 = '0;
        sDot8 = '0;
        mDot8 = '0;
        uDot8 = '0;
        sSad = '0;
        uSad = '0;
        aByte = '0;
        bByte = '0;
        aHalf = '0;
        bHalf = '0;
        hx = '0;
        hy = '0;
        byteSum = '0;
        avgSum = '0;
        byteProd = '0;
        for (int i = 0; i < 2; i++)
        begin
            aHalf = srcA[16*i +: 16];
            bHalf = srcB[16*i +: 16];
            hx = 34'($signed(aHalf));
            hy = 34'($signed(bHalf));
            dualAdd[16*i +: 16] = clampS16(hx + hy);
            dualSub[16*i +: 16] = clampS16(hx - hy);
            dualMul[16*i +: 16] = clampS16(hx * hy);
            dualAbs[16*i +: 16] = clampS16((hx < 0) ? -hx : hx);
            // Two full products can pass 32 bits; the sum wraps, it is not clipped
            sDot16 = sDot16 + 32'($signed(aHalf) * $signed(bHalf));
            uDot16 = uDot16 + 32'(aHalf * bHalf);
        end
        for (int i = 0; i < 4; i++)
        begin
            aByte = srcA[8*i +: 8];
            bByte = srcB[8*i +: 8];
            byteSum = $signed({2'b00, aByte}) + 10'($signed(bByte));
            if (byteSum > BYTE_U8_MAX)
                quadAdd[8*i +: 8] = BYTE_U8_MAX[7:0];
            else if (byteSum < BYTE_ZERO)
                quadAdd[8*i +: 8] = BYTE_ZERO[7:0];
            else
                quadAdd[8*i +: 8] = byteSum[7:0];
            avgSum = {1'b0, aByte} + {1'b0, bByte} + AVG_ROUND;
            quadAvg[8*i +: 8] = avgSum[8:1];
            byteProd = {8'h00, aByte} * {8'h00, bByte};
            quadMulHigh[8*i +: 8] = byteProd[15:8];
            sDot8 = sDot8 + 32'($signed(aByte) * $signed(bByte));
            mDot8 = mDot8 + 32'($signed(aByte) * $signed({1'b0, bByte}));
            uDot8 = uDot8 + 32'(aByte * bByte);
            sSad = sSad + {22'h00_0000, absByteDiff(10'($signed(aByte)) - 10'($signed(bByte)))};
            uSad = uSad + {22'h00_0000,
                absByteDiff($signed({2'b00, aByte}) - $signed({2'b00, bByte}))};
        end
    end

    // Result select; one result per issued operation, one cycle later
    always_comb
    begin
        next_resValid = opValid;
        next_resIllegal = 1'b0;
        next_resData = resData;
        if (opValid)
        begin
            unique case (opCode)
                OP_SADD: next_resData = clampS32(wideA + wideB);
                OP_UADD: next_resData = clampU32(zeroA + zeroB);
                OP_SSUB: next_resData = clampS32(wideA - wideB);
                OP_USUB: next_resData = clampU32(zeroA - zeroB);
                OP_SMUL: next_resData = clampS32(wideA * wideB);
                OP_UMUL: next_resData = clampU32(zeroA * zeroB);
                OP_SABS: next_resData = clampS32((wideA < 0) ? -wideA : wideA);
                OP_DUAL_ADD: next_resData = dualAdd;
                OP_DUAL_SUB: next_resData = dualSub;
                OP_DUAL_MUL: next_resData = dualMul;
                OP_DUAL_ABS: next_resData = dualAbs;
                OP_QUAD_ADD_US: next_resData = quadAdd;
                OP_SIGNED_HALFWORD_DOT: next_resData = sDot16;
                OP_UNSIGNED_HALFWORD_DOT: next_resData = uDot16;
                OP_SIGNED_BYTE_DOT: next_resData = sDot8;
                OP_MIXED_BYTE_DOT: next_resData = mDot8;
                OP_UNSIGNED_BYTE_DOT: next_resData = uDot8;
                OP_MERGE_LOW:
                    next_resData = {srcA[15:8], srcB[15:8], srcA[7:0], srcB[7:0]};
                OP_MERGE_HIGH:
                    next_resData = {srcA[31:24], srcB[31:24], srcA[23:16], srcB[23:16]};
                OP_JOIN_LOW_HALFWORDS: next_resData = {srcA[15:0], srcB[15:0]};
                OP_JOIN_HIGH_HALFWORDS: next_resData = {srcA[31:16], srcB[31:16]};
                OP_PACK_LOW_BYTES: next_resData = {16'h0000, srcA[7:0], srcB[7:0]};
                OP_QUAD_AVG: next_resData = quadAvg;
                OP_QUAD_MUL_HIGH: next_resData = quadMulHigh;
                OP_SIGNED_BYTE_SAD: next_resData = sSad;
                OP_UNSIGNED_BYTE_SAD: next_resData = uSad;
                default:
                begin
                    // Unused codes still answer, so the issue logic never waits
                    next_resData = RESULT_RESET;
                    next_resIllegal = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            resValid <= 1'b0;
            resData <= RESULT_RESET;
            resIllegal <= 1'b0;
        end
        else
        begin
            resValid <= next_resValid;
            resData <= next_resData;
            resIllegal <= next_resIllegal;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    property p_one_result;
        opValid |=> resValid;
    endproperty
    a_one_result: assert property (p_one_result) else $error("No result after issue");

    property p_sadd_no_wrap;
        opValid && opCode == OP_SADD && !srcA[31] && !srcB[31]
            |=> !resData[31] && resData >= $past(srcA) && resData >= $past(srcB);
    endproperty
    a_sadd_no_wrap: assert property (p_sadd_no_wrap) else $error("Signed add wrapped");

    property p_usub_floor;
        opValid && opCode == OP_USUB && srcA < srcB |=> resData == 32'h0000_0000;
    endproperty
    a_usub_floor: assert property (p_usub_floor) else $error("Unsigned sub not floored");

    property p_quad_add_neg;
        opValid && opCode == OP_QUAD_ADD_US && srcB[7] |=> resData[7:0] <= $past(srcA[7:0]);
    endproperty
    a_quad_add_neg: assert property (p_quad_add_neg) else $error("Quad add byte grew");

    property p_sad_equal;
        opValid && (opCode == OP_SIGNED_BYTE_SAD || opCode == OP_UNSIGNED_BYTE_SAD)
            && srcA == srcB |=> resData == 32'h0000_0000;
    endproperty
    a_sad_equal: assert property (p_sad_equal) else $error("SAD of equal words nonzero");

    property p_dual_abs_pos;
        opValid && opCode == OP_DUAL_ABS |=> !resData[31] && !resData[15];
    endproperty
    a_dual_abs_pos: assert property (p_dual_abs_pos) else $error("Dual abs negative");

    property p_merge_high;
        opValid && opCode == OP_MERGE_HIGH
            |=> resData[31:24] == $past(srcA[31:24]) && resData[23:16] == $past(srcB[31:24]);
    endproperty
    a_merge_high: assert property (p_merge_high) else $error("High merge misplaced");

    property p_join_low;
        opValid && opCode == OP_JOIN_LOW_HALFWORDS |=> resData[15:0] == $past(srcB[15:0]);
    endproperty
    a_join_low: assert property (p_join_low) else $error("Low join misplaced");

    property p_pack_bytes;
        opValid && opCode == OP_PACK_LOW_BYTES |=> resData[7:0] == $past(srcB[7:0]);
    endproperty
    a_pack_bytes: assert property (p_pack_bytes) else $error("Byte pack misplaced");

    property p_udot_ones;
        opValid && opCode == OP_UNSIGNED_BYTE_DOT && srcB == ONES_PER_BYTE
            |=> resData == 32'($past(srcA[7:0])) + 32'($past(srcA[15:8]))
                + 32'($past(srcA[23:16])) + 32'($past(srcA[31:24]));
    endproperty
    a_udot_ones: assert property (p_udot_ones) else $error("Byte dot sum wrong");

    property p_qmul_zero;
        opValid && opCode == OP_QUAD_MUL_HIGH && srcB[7:0] == 8'h00 |=> resData[7:0] == 8'h00;
    endproperty
    a_qmul_zero: assert property (p_qmul_zero) else $error("Quad multiply lane wrong");

    property p_avg_same;
        opValid && opCode == OP_QUAD_AVG && srcA == srcB |=> resData == $past(srcA);
    endproperty
    a_avg_same: assert property (p_avg_same) else $error("Average of equal bytes wrong");

    c_smul_clip: cover property (opValid && opCode == OP_SMUL ##1 resData == 32'h7FFF_FFFF);
    c_quad_add: cover property (opValid && opCode == OP_QUAD_ADD_US ##1 resValid);
    c_sad: cover property (opValid && opCode == OP_SIGNED_BYTE_SAD ##1 resData != 32'h0000_0000);
    c_back_to_back: cover property (opValid [*3]);

endmodule : smca_alu

// ### bench/smca_issue_model.sv
`timescale 1ns/1ps
module smca_issue_model (
    input wire logic ref_clk,
    output logic opValid,
    output smca_pkg::smca_op_t opCode,
    output logic [31:0] srcA,
    output logic [31:0] srcB
);
    import smca_pkg::*;
    initial
    begin
        opValid = 1'b0;
        opCode = OP_SADD;
        srcA = 32'h0000_0000;
        srcB = 32'h0000_0000;
    end
    // One opcode and two sources per issued operation, held to the taking edge
    task automatic send(input smca_op_t op, input logic [31:0] a, input logic [31:0] b);
        opValid = 1'b1;
        opCode = op;
        srcA = a;
        srcB = b;
        @(posedge ref_clk);
    endtask : send
    // Released operands flip so a stale value can never pass for a live one
    task automatic release_bus();
        opValid = 1'b0;
        srcA = ~srcA;
        srcB = ~srcB;
    endtask : release_bus
endmodule : smca_issue_model

// ### bench/smca_alu_tb.sv
`timescale 1ns/1ps
module smca_alu_tb;
    import smca_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst;
    logic opValid;
    smca_op_t opCode;
    logic [31:0] srcA;
    logic [31:0] srcB;
    logic resValid;
    logic [31:0] resData;
    logic resIllegal;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    smca_issue_model i_issue (.ref_clk(ref_clk), .opValid(opValid), .opCode(opCode),
        .srcA(srcA), .srcB(srcB));
    smca_alu i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .opValid(opValid),
        .opCode(opCode), .srcA(srcA), .srcB(srcB), .resValid(resValid),
        .resData(resData), .resIllegal(resIllegal));

    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end

    // Whole run needs about 90 cycles; the ceiling of 2000 leaves wide margin
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 2000)
        begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apply_reset(input int n);
        sys_rst = 1'b1;
        repeat (n) @(negedge ref_clk);
        check("resValid rst", resValid, 1'b0);
        check("resIllegal rst", resIllegal, 1'b0);
        check("resData rst", resData, 32'h0000_0000);
        sys_rst = 1'b0;
    endtask : apply_reset

    task automatic run_op(input smca_op_t op, input logic [31:0] a, input logic [31:0] b,
        input logic [31:0] exp);
        i_issue.send(op, a, b);
        @(negedge ref_clk);
        check("resValid", resValid, 1'b1);
        check("resIllegal", resIllegal, 1'b0);
        check(op.name(), resData, exp);
        i_issue.release_bus();
        @(negedge ref_clk);
        check("resValid idle", resValid, 1'b0);
        check("resData held", resData, exp);
    endtask : run_op

    task automatic word_ops();
        run_op(OP_SADD, 32'h7FFF_FFFF, 32'h0000_0001, 32'h7FFF_FFFF);
        run_op(OP_SADD, 32'h8000_0000, 32'hFFFF_FFFF, 32'h8000_0000);
        run_op(OP_UADD, 32'hFFFF_FFF0, 32'h0000_0020, 32'hFFFF_FFFF);
        run_op(OP_SSUB, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000);
        run_op(OP_USUB, 32'h0000_0005, 32'h0000_0006, 32'h0000_0000);
        run_op(OP_SMUL, 32'h0001_0000, 32'h0001_0000, 32'h7FFF_FFFF);
        run_op(OP_SMUL, 32'hFFFF_FFFD, 32'h0000_0007, 32'hFFFF_FFEB);
        run_op(OP_UMUL, 32'h0001_0000, 32'h0001_0000, 32'hFFFF_FFFF);
        run_op(OP_SABS, 32'h8000_0000, 32'h1234_5678, 32'h7FFF_FFFF);
        run_op(OP_SABS, 32'hFFFF_FFFB, 32'h0000_0000, 32'h0000_0005);
    endtask : word_ops

    task automatic dual_ops();
        run_op(OP_DUAL_ADD, 32'h7FFF_0005, 32'h0001_0003, 32'h7FFF_0008);
        run_op(OP_DUAL_SUB, 32'h8000_0005, 32'h0001_0007, 32'h8000_FFFE);
        run_op(OP_DUAL_MUL, 32'h0100_FFFE, 32'h0100_0003, 32'h7FFF_FFFA);
        run_op(OP_DUAL_ABS, 32'h8000_FFF9, 32'h0000_0000, 32'h7FFF_0007);
    endtask : dual_ops

    task automatic byte_ops();
        run_op(OP_QUAD_ADD_US, 32'hFF20_0080, 32'h01F0_807F, 32'hFF10_00FF);
        run_op(OP_QUAD_ADD_US, 32'h0102_0310, 32'hFF7F_FEF0, 32'h0081_0100);
        run_op(OP_QUAD_AVG, 32'hFF80_7F01, 32'hFF80_7F01, 32'hFF80_7F01);
        run_op(OP_QUAD_MUL_HIGH, 32'hFFFF_FFFF, 32'h8040_2000, 32'h7F3F_1F00);
        run_op(OP_SIGNED_BYTE_SAD, 32'h80FF_7F01, 32'h80FF_7F01, 32'h0000_0000);
        run_op(OP_QUAD_AVG, 32'hFF01_0203, 32'hFF00_0204, 32'hFF01_0204);
        run_op(OP_QUAD_MUL_HIGH, 32'hFF80_1002, 32'hFF02_1080, 32'hFE01_0101);
        run_op(OP_SIGNED_BYTE_SAD, 32'h7F80_0005, 32'h807F_0A00, 32'h0000_020D);
        run_op(OP_UNSIGNED_BYTE_SAD, 32'h7F80_0005, 32'h807F_0A00, 32'h0000_0011);
    endtask : byte_ops

    task automatic dot_ops();
        run_op(OP_SIGNED_BYTE_DOT, 32'hFF02_807F, 32'hFF03_8001, 32'h0000_4086);
        run_op(OP_MIXED_BYTE_DOT, 32'hFF02_807F, 32'hFF03_8001, 32'hFFFF_BF86);
        run_op(OP_UNSIGNED_BYTE_DOT, 32'hFF02_807F, 32'hFF03_8001, 32'h0001_3E86);
        run_op(OP_UNSIGNED_BYTE_DOT, 32'h0102_03FF, 32'h0101_0101, 32'h0000_0105);
        run_op(OP_SIGNED_HALFWORD_DOT, 32'h8000_0002, 32'h8000_FFFD, 32'h3FFF_FFFA);
        run_op(OP_UNSIGNED_HALFWORD_DOT, 32'hFFFF_0002, 32'hFFFF_0003, 32'hFFFE_0007);
    endtask : dot_ops

    task automatic merge_ops();
        run_op(OP_MERGE_LOW, 32'h1122_3344, 32'h5566_7788, 32'h3377_4488);
        run_op(OP_MERGE_HIGH, 32'h1122_3344, 32'h5566_7788, 32'h1155_2266);
        run_op(OP_JOIN_LOW_HALFWORDS, 32'h1122_3344, 32'h5566_7788, 32'h3344_7788);
        run_op(OP_JOIN_HIGH_HALFWORDS, 32'h1122_3344, 32'h5566_7788, 32'h1122_5566);
        run_op(OP_PACK_LOW_BYTES, 32'h1122_3344, 32'h5566_7788, 32'h0000_4488);
    endtask : merge_ops

    task automatic back_to_back();
        i_issue.send(OP_UADD, 32'h0000_0001, 32'h0000_0002);
        @(negedge ref_clk);
        check("first result", resData, 32'h0000_0003);
        i_issue.send(OP_QUAD_AVG, 32'h0000_0000, 32'h0000_0001);
        @(negedge ref_clk);
        check("second valid", resValid, 1'b1);
        check("second result", resData, 32'h0000_0001);
        i_issue.send(OP_SADD, 32'h0000_0005, 32'hFFFF_FFFE);
        @(negedge ref_clk);
        check("third valid", resValid, 1'b1);
        check("third result", resData, 32'h0000_0003);
        i_issue.release_bus();
        @(negedge ref_clk);
    endtask : back_to_back

    task automatic illegal_code();
        i_issue.send(smca_op_t'(5'd26), 32'h1234_5678, 32'h1111_1111);
        @(negedge ref_clk);
        check("illegal flag", resIllegal, 1'b1);
        check("illegal valid", resValid, 1'b1);
        check("illegal data", resData, 32'h0000_0000);
        i_issue.release_bus();
        @(negedge ref_clk);
        check("illegal idle", resIllegal, 1'b0);
    endtask : illegal_code

    initial
    begin
        sys_rst = 1'b1;
        apply_reset(12);
        word_ops();
        dual_ops();
        byte_ops();
        dot_ops();
        merge_ops();
        illegal_code();
        // Leaves a nonzero result so the mid-run reset has something to clear
        back_to_back();
        apply_reset(2);
        run_op(OP_UADD, 32'h0000_0010, 32'h0000_0020, 32'h0000_0030);
        stop_test();
    end
endmodule : smca_alu_tb
